// [logic/raster_timing.sv]
/*
  Raster timing generator for TFT panel, CRT and NTSC/PAL TV output,
  with its byte-wide configuration registers on an AXI4-Lite slave.
  Assumes aclk is the selected pixel clock source and, in TV mode,
  the subcarrier-x4 source; all outputs are on the aclk domain.
*/
// Notes on behaviour
// - pixel clock is the source divided by two, four, six or eight
// - TFT display period is (width field plus one) times eight pixels
// - TFT non-display is (field plus one) times eight; line is their sum
// - TFT display lines are ten-bit count plus one, from two registers
// - TFT frame adds non-display lines of six-bit field plus one
// - TFT line sync low for (pulse field plus one) times eight pixels
// - TFT frame sync low for pulse field plus one lines
// - shift clock half high half low; data changes half period before fall
// - frame sync falls start field times eight plus one before line sync
// - data enable lasts exactly the horizontal display period
// - data enable ends start times eight plus six or eight before line sync
// - data enable rises non-display minus start minus six or eight after
// - CRT frame is display lines plus seven-bit non-display plus one
// - CRT vertical sync low for pulse field plus one lines
// - CRT vertical sync falls (start field plus one) times eight after line
// - CRT and TV active video is (width field plus one) times eight
// - TV front porch is (start plus one) times eight minus seven or five
// - TV blanking is non-display times eight plus six or seven
// - TV sync, breezeway, burst, equalizing, serration, half line are fixed
// - TV field is half the display lines plus blanking per field parity
// - TV vertical sync at position field plus four, four and half or five
module raster_timing (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // tft panel
  output logic             panel_shift_clock,
  output logic             line_sync,
  output logic             frame_sync,
  output logic             data_enable_out,
  // crt
  output logic             crt_vertical_sync,
  // tv
  output logic             tv_sync_n,
  output logic             tv_hblank,
  output logic             tv_vblank,
  output logic             tv_burst
);

  // register slot decode; slot_control is the timing control register
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    unique case (idx)
      raster_timing_pkg::idx_tft_horiz_display_width:    slot_of = 6'h20;
      raster_timing_pkg::idx_tft_horiz_nondisplay:       slot_of = 6'h21;
      raster_timing_pkg::idx_tft_line_pulse_start:       slot_of = 6'h22;
      raster_timing_pkg::idx_tft_line_pulse_width:       slot_of = 6'h23;
      raster_timing_pkg::idx_tft_vert_display_low:       slot_of = 6'h24;
      raster_timing_pkg::idx_tft_vert_display_high:      slot_of = 6'h25;
      raster_timing_pkg::idx_tft_vert_nondisplay:        slot_of = 6'h26;
      raster_timing_pkg::idx_tft_frame_pulse_width:      slot_of = 6'h27;
      raster_timing_pkg::idx_crt_tv_horiz_display_width: slot_of = 6'h28;
      raster_timing_pkg::idx_crt_tv_horiz_nondisplay:    slot_of = 6'h29;
      raster_timing_pkg::idx_crt_tv_hsync_start:         slot_of = 6'h2a;
      raster_timing_pkg::idx_crt_tv_vert_display_low:    slot_of = 6'h2b;
      raster_timing_pkg::idx_crt_tv_vert_display_high:   slot_of = 6'h2c;
      raster_timing_pkg::idx_crt_tv_vert_nondisplay:     slot_of = 6'h2d;
      raster_timing_pkg::idx_crt_tv_vsync_position:      slot_of = 6'h2e;
      raster_timing_pkg::idx_crt_vsync_pulse_width:      slot_of = 6'h2f;
      raster_timing_pkg::idx_timing_control:             slot_of = 6'h30;
      default:                                           slot_of = 6'h00;
    endcase
  endfunction

  // (field plus one) times eight
  function automatic logic [11:0] units8(input logic [7:0] f);
    units8 = 12'({4'h0, f} + 12'h001) << raster_timing_pkg::unit_shift;
  endfunction

  // distance from b forward to a within one line
  function automatic logic [11:0] wrap_diff(input logic [11:0] a, input logic [11:0] b,
                                           input logic [11:0] total);
    wrap_diff = (a >= b) ? 12'(a - b) : 12'(a + total - b);
  endfunction

  logic [7:0]  cfg_reg [0:raster_timing_pkg::num_slots-1];
  logic [11:0] awaddr_reg;
  logic        aw_held_reg;
  logic [7:0]  wdata_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // ---------------- bus slave ----------------
  wire [5:0] wr_slot = slot_of(awaddr_reg[9:2]);
  wire [5:0] rd_slot = slot_of(s_axi_araddr[9:2]);
  wire       wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire       wr_hit  = wr_slot[5] && awaddr_reg[11:10] == 2'b00;
  wire       rd_fire = s_axi_arvalid && !rvalid_reg;
  wire       rd_stat = s_axi_araddr[11:10] == 2'b00 &&
                       (s_axi_araddr[9:2] == raster_timing_pkg::idx_status_line ||
                        s_axi_araddr[9:2] == raster_timing_pkg::idx_status_flags);
  wire       rd_hit  = (rd_slot[5] && s_axi_araddr[11:10] == 2'b00) || rd_stat;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 8'h00;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= raster_timing_pkg::axi_okay;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= s_axi_wstrb[0];
        wdata_reg  <= s_axi_wdata[7:0];
      end
      // a write without lane 0 still completes, storing nothing
      if (s_axi_wvalid && !w_held_reg && !s_axi_wstrb[0]) begin
        w_held_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? raster_timing_pkg::axi_okay : raster_timing_pkg::axi_slverr;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  logic wstrb0_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      wstrb0_reg <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < raster_timing_pkg::num_slots; i++) begin
        cfg_reg[i] <= 8'h00;
      end
    end else if (wr_fire && wr_hit && wstrb0_reg) begin
      cfg_reg[wr_slot[4:0]] <= wdata_reg;
    end
  end

  // ---------------- control and mode selection ----------------
  wire [7:0]  ctl      = cfg_reg[raster_timing_pkg::slot_control];
  wire        run      = ctl[raster_timing_pkg::ctl_enable];
  wire        pal      = ctl[raster_timing_pkg::ctl_pal];
  wire        bpp16    = ctl[raster_timing_pkg::ctl_bpp16];
  wire [1:0]  div_sel  = ctl[raster_timing_pkg::ctl_div_lo +: 2];
  raster_timing_pkg::out_mode_t mode;
  assign mode = raster_timing_pkg::out_mode_t'(ctl[raster_timing_pkg::ctl_mode_lo +: 2]);
  wire        is_tft   = mode == raster_timing_pkg::mode_tft;
  wire        is_crt   = mode == raster_timing_pkg::mode_crt;
  wire        is_tv    = mode == raster_timing_pkg::mode_tv;

  // tft fields
  wire [11:0] tft_hdp   = units8({1'b0, cfg_reg[0][6:0]});
  wire [11:0] tft_horiz_nondisplay_period  = units8({3'b000, cfg_reg[1][4:0]});
  wire [11:0] tft_start = 12'({cfg_reg[2][4:0], 3'b000});
  wire [11:0] tft_lpw   = units8({4'h0, cfg_reg[3][3:0]});
  wire [10:0] tft_vdp   = 11'({cfg_reg[5][1:0], cfg_reg[4]}) + 11'h001;
  wire [10:0] tft_vert_nondisplay_period  = 11'(cfg_reg[6][5:0]) + 11'h001;
  // crt and tv fields
  wire [11:0] ct_hdp    = units8({1'b0, cfg_reg[8][6:0]});
  wire [11:0] crt_horiz_nondisplay_period  = units8({2'b00, cfg_reg[9][5:0]});
  wire [11:0] tv_hblank_len = 12'({cfg_reg[9][5:0], 3'b000}) +
                              (pal ? raster_timing_pkg::tv_blank_pal
                                   : raster_timing_pkg::tv_blank_ntsc);
  wire [11:0] ct_hs     = units8({2'b00, cfg_reg[10][5:0]});
  wire [10:0] ct_vdp    = 11'({cfg_reg[12][1:0], cfg_reg[11]}) + 11'h001;
  wire [10:0] ct_vert_nondisplay_period   = 11'(cfg_reg[13][6:0]) + 11'h001;

  wire [11:0] horiz_display_period       = is_tft ? tft_hdp : ct_hdp;
  wire [11:0] horiz_nondisplay_period      = is_tft ? tft_horiz_nondisplay_period : (is_tv ? tv_hblank_len : crt_horiz_nondisplay_period);
  wire [11:0] line_tot  = 12'(horiz_display_period + horiz_nondisplay_period);
  wire [10:0] vert_display_period       = is_tft ? tft_vdp : ct_vdp;
  wire [10:0] frame_tot = 11'(vert_display_period + (is_tft ? tft_vert_nondisplay_period : ct_vert_nondisplay_period));

  // ---------------- pixel clock divider ----------------
  logic [1:0]  half_cnt_reg;
  logic        phase_reg;
  wire         half_tick = half_cnt_reg == div_sel;
  wire         pix_tick  = half_tick && phase_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      half_cnt_reg <= 2'b00;
      phase_reg    <= 1'b0;
    end else begin
      half_cnt_reg <= half_tick ? 2'b00 : 2'(half_cnt_reg + 2'b01);
      phase_reg    <= half_tick ? !phase_reg : phase_reg;
    end
  end

  // ---------------- counters ----------------
  logic [11:0] h_reg;
  logic [10:0] v_reg;
  logic [1:0]  field_reg;
  wire         line_end = h_reg == 12'(line_tot - 12'h001);
  // tv field length depends on field parity
  wire [10:0]  tv_blank_lines = 11'(cfg_reg[13][6:0]) + (field_reg[0] ? 11'h002 : 11'h001);
  wire [10:0]  tv_field_tot   = 11'(ct_vdp >> 1) + tv_blank_lines;
  wire [10:0]  v_tot    = is_tv ? tv_field_tot : frame_tot;
  wire         frame_end = line_end && v_reg == 11'(v_tot - 11'h001);
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      h_reg     <= 12'h000;
      v_reg     <= 11'h000;
      field_reg <= 2'b00;
    end else if (pix_tick) begin
      h_reg <= line_end ? 12'h000 : 12'(h_reg + 12'h001);
      if (line_end) begin
        v_reg <= frame_end ? 11'h000 : 11'(v_reg + 11'h001);
      end
      if (frame_end) begin
        field_reg <= (pal || field_reg[0]) ? 2'(field_reg + 2'b01) : 2'b01;
      end
    end
  end

  // ---------------- tft data enable ----------------
  wire [11:0] de_lead  = bpp16 ? raster_timing_pkg::de_lead_16bpp
                               : raster_timing_pkg::de_lead_8bpp;
  // rise point relative to line sync fall; may be negative before the wrap
  wire [12:0] de_raw   = 13'({1'b0, tft_horiz_nondisplay_period} + {1'b0, line_tot}) -
                         13'({1'b0, tft_start}) - 13'({1'b0, de_lead});
  wire [11:0] de_start = (de_raw >= {1'b0, line_tot}) ? 12'(de_raw - {1'b0, line_tot})
                                                      : de_raw[11:0];
  wire        de_now   = wrap_diff(h_reg, de_start, line_tot) < tft_hdp &&
                         v_reg < tft_vdp;

  // ---------------- vertical pulse for frame sync and crt sync ----------------
  // fall point within the line, and the line on which it first falls
  wire [11:0] fr_pos   = 12'(line_tot - tft_start - 12'h001);
  wire [11:0] crt_pos  = (ct_hs < line_tot) ? ct_hs : 12'(line_tot - 12'h001);
  wire [11:0] vp_pos   = is_tft ? fr_pos : crt_pos;
  wire [10:0] vp_line  = is_tft ? 11'(frame_tot - 11'h001) : vert_display_period;
  wire [3:0]  vp_width = is_tft ? {1'b0, cfg_reg[7][2:0]} : {1'b0, cfg_reg[15][2:0]};
  logic [3:0] vp_cnt_reg;
  logic       vp_low_reg;
  // compare one pixel early, the output register adds one
  wire        vp_at    = h_reg == 12'(vp_pos - 12'h001);
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      vp_cnt_reg <= 4'h0;
      vp_low_reg <= 1'b0;
    end else if (pix_tick && vp_at) begin
      if (v_reg == vp_line) begin
        vp_cnt_reg <= 4'h0;
        vp_low_reg <= 1'b1;
      end else if (vp_low_reg) begin
        vp_low_reg <= vp_cnt_reg != vp_width;
        vp_cnt_reg <= 4'(vp_cnt_reg + 4'h1);
      end
    end
  end

  // ---------------- tv horizontal and vertical ----------------
  wire [11:0] tv_fp    = 12'(ct_hs - (bpp16 ? raster_timing_pkg::tv_fp_16bpp
                                            : raster_timing_pkg::tv_fp_8bpp));
  wire [11:0] sync_len = pal ? raster_timing_pkg::tv_sync_pal : raster_timing_pkg::tv_sync_ntsc;
  wire [11:0] brz_len  = pal ? raster_timing_pkg::tv_brz_pal : raster_timing_pkg::tv_brz_ntsc;
  wire [11:0] bst_len  = pal ? raster_timing_pkg::tv_burst_pal
                             : raster_timing_pkg::tv_burst_ntsc;
  wire [11:0] eq_len   = pal ? raster_timing_pkg::tv_eq_pal : raster_timing_pkg::tv_eq_ntsc;
  wire [11:0] serr_len = pal ? raster_timing_pkg::tv_serr_pal : raster_timing_pkg::tv_serr_ntsc;
  wire [11:0] half_len = pal ? raster_timing_pkg::tv_half_pal : raster_timing_pkg::tv_half_ntsc;
  wire [11:0] sync_at  = 12'(ct_hdp + tv_fp);
  wire [11:0] h_in_sync  = wrap_diff(h_reg, sync_at, line_tot);
  wire        hs_now   = h_in_sync < sync_len;
  wire        bst_now  = h_in_sync >= 12'(sync_len + brz_len) &&
                         h_in_sync < 12'(sync_len + brz_len + bst_len);
  wire [11:0] h_half   = (h_reg >= half_len) ? 12'(h_reg - half_len) : h_reg;
  wire [11:0] half_idx = 12'({v_reg, h_reg >= half_len});
  // sync position in half lines, per standard and field
  wire [11:0] voff     = field_reg[0] ? raster_timing_pkg::tv_voff_4h
                       : (pal ? raster_timing_pkg::tv_voff_5 : raster_timing_pkg::tv_voff_4);
  wire [11:0] vs_half  = 12'({cfg_reg[14][6:0], 1'b0} + voff);
  wire        pre_eq   = half_idx + raster_timing_pkg::tv_vs_halves >= vs_half &&
                         half_idx < vs_half;
  wire        in_vs    = half_idx >= vs_half &&
                         half_idx < 12'(vs_half + raster_timing_pkg::tv_vs_halves);
  wire        post_eq  = half_idx >= 12'(vs_half + raster_timing_pkg::tv_vs_halves) &&
                         half_idx < 12'(vs_half + 2 * raster_timing_pkg::tv_vs_halves);
  wire        tv_vbl   = v_reg < tv_blank_lines;
  wire        tv_sync_low = in_vs ? h_half < 12'(half_len - serr_len)
                          : (pre_eq || post_eq) ? h_half < eq_len : hs_now;

  // ---------------- registered outputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      line_sync         <= 1'b1;
      frame_sync        <= 1'b1;
      data_enable_out   <= 1'b0;
      crt_vertical_sync <= 1'b1;
      tv_sync_n         <= 1'b1;
      tv_hblank         <= 1'b0;
      tv_vblank         <= 1'b0;
      tv_burst          <= 1'b0;
    end else if (pix_tick) begin
      // values for the pixel about to start, in step with the rising edge
      line_sync         <= !((is_tft || is_crt) && h_reg < tft_lpw);
      frame_sync        <= !(is_tft && vp_low_reg);
      data_enable_out   <= is_tft && de_now;
      crt_vertical_sync <= !(is_crt && vp_low_reg);
      tv_sync_n         <= !(is_tv && tv_sync_low);
      tv_hblank         <= is_tv && h_reg >= ct_hdp;
      tv_vblank         <= is_tv && tv_vbl;
      tv_burst          <= is_tv && bst_now && !tv_vbl;
    end
  end

  // shift clock high for the first half of each pixel
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      panel_shift_clock <= 1'b0;
    end else begin
      panel_shift_clock <= is_tft && (half_tick ? phase_reg : !phase_reg);
    end
  end

  // ---------------- read data ----------------
  wire [7:0] rd_byte = (s_axi_araddr[9:2] == raster_timing_pkg::idx_status_line) ? v_reg[7:0]
                     : (s_axi_araddr[9:2] == raster_timing_pkg::idx_status_flags)
                       ? {data_enable_out, tv_vblank, field_reg, 1'b0, v_reg[10:8]}
                     : (rd_slot[5] ? cfg_reg[rd_slot[4:0]] : 8'h00);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= raster_timing_pkg::axi_okay;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? raster_timing_pkg::axi_okay : raster_timing_pkg::axi_slverr;
      rdata_reg  <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// [logic/raster_timing_pkg.sv]
/*
  Constants shared by the raster timing generator: register indexes,
  field positions, mode codes and fixed TV interval lengths.
  Assumes a 32-bit AXI4-Lite master and byte-wide registers, one per word.
*/
package raster_timing_pkg;

  // register indexes, byte address is four times the index
  localparam logic [7:0] idx_tft_horiz_display_width    = 8'h32;
  localparam logic [7:0] idx_tft_horiz_nondisplay       = 8'h34;
  localparam logic [7:0] idx_tft_line_pulse_start       = 8'h35;
  localparam logic [7:0] idx_tft_line_pulse_width       = 8'h36;
  localparam logic [7:0] idx_tft_vert_display_low       = 8'h38;
  localparam logic [7:0] idx_tft_vert_display_high      = 8'h39;
  localparam logic [7:0] idx_tft_vert_nondisplay        = 8'h3a;
  localparam logic [7:0] idx_tft_frame_pulse_width      = 8'h3c;
  localparam logic [7:0] idx_crt_tv_horiz_display_width = 8'h50;
  localparam logic [7:0] idx_crt_tv_horiz_nondisplay    = 8'h52;
  localparam logic [7:0] idx_crt_tv_hsync_start         = 8'h53;
  localparam logic [7:0] idx_crt_tv_vert_display_low    = 8'h56;
  localparam logic [7:0] idx_crt_tv_vert_display_high   = 8'h57;
  localparam logic [7:0] idx_crt_tv_vert_nondisplay     = 8'h58;
  localparam logic [7:0] idx_crt_tv_vsync_position      = 8'h59;
  localparam logic [7:0] idx_crt_vsync_pulse_width      = 8'h5a;
  localparam logic [7:0] idx_timing_control             = 8'h60;
  localparam logic [7:0] idx_status_line                = 8'h61;
  localparam logic [7:0] idx_status_flags               = 8'h62;
  localparam int         num_slots                      = 17;
  localparam logic [4:0] slot_control                   = 5'h10;

  // control register fields
  localparam int ctl_enable = 0;
  localparam int ctl_mode_lo = 1;
  localparam int ctl_pal = 3;
  localparam int ctl_bpp16 = 4;
  localparam int ctl_div_lo = 5;

  typedef enum logic [1:0] {
    mode_tft = 2'b00,
    mode_crt = 2'b01,
    mode_tv  = 2'b10,
    mode_off = 2'b11
  } out_mode_t;

  localparam logic [1:0] axi_okay   = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;

  // length arithmetic
  localparam int         unit_shift    = 3;
  localparam logic [11:0] de_lead_8bpp  = 12'h006;
  localparam logic [11:0] de_lead_16bpp = 12'h008;
  localparam logic [11:0] tv_fp_8bpp    = 12'h007;
  localparam logic [11:0] tv_fp_16bpp   = 12'h005;
  localparam logic [11:0] tv_blank_ntsc = 12'h006;
  localparam logic [11:0] tv_blank_pal  = 12'h007;

  // fixed TV intervals in subcarrier-x4 clocks: ntsc, pal
  localparam logic [11:0] tv_sync_ntsc  = 12'd67;
  localparam logic [11:0] tv_sync_pal   = 12'd83;
  localparam logic [11:0] tv_brz_ntsc   = 12'd9;
  localparam logic [11:0] tv_brz_pal    = 12'd16;
  localparam logic [11:0] tv_burst_ntsc = 12'd39;
  localparam logic [11:0] tv_burst_pal  = 12'd44;
  localparam logic [11:0] tv_eq_ntsc    = 12'd33;
  localparam logic [11:0] tv_eq_pal     = 12'd41;
  localparam logic [11:0] tv_serr_ntsc  = 12'd67;
  localparam logic [11:0] tv_serr_pal   = 12'd83;
  localparam logic [11:0] tv_half_ntsc  = 12'd455;
  localparam logic [11:0] tv_half_pal   = 12'd568;
  // vertical sync offset in half lines: 4, 4.5 and 5 lines
  localparam logic [11:0] tv_voff_4     = 12'd8;
  localparam logic [11:0] tv_voff_4h    = 12'd9;
  localparam logic [11:0] tv_voff_5     = 12'd10;
  // vertical sync and equalizing spans in half lines
  localparam logic [11:0] tv_vs_halves  = 12'd6;

  localparam real clk_period_ns = 8.0;

endpackage

// [tb/panel_model.sv]
/* tft panel model: latches the raster outputs on the falling shift clock
   edge and keeps the last spans in pixels; assumes tft mode */
module panel_model (
  input wire logic panel_shift_clock, line_sync, frame_sync, data_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   h, dc, de_len, de_rise, line_len, low_len, lead, lines, frame_lines, frames, fh = -1;
  logic lq = 1'h1, fq = 1'h1, dq = 1'h0;
  always @(negedge panel_shift_clock) begin
    h++;
    dc += int'(data_enable_out);
    if (!dq && data_enable_out) de_rise = h;
    if (dq && !data_enable_out) begin de_len = dc; dc = 0; end
    if (fq && !frame_sync) begin fh = h; frame_lines = lines; lines = 0; frames++; end
    if (lq && !line_sync) begin line_len = h; lead = (fh < 0) ? lead : h - fh; fh = -1; h = 0; lines++; end
    if (!lq && line_sync) low_len = h;
    {lq, fq, dq} = {line_sync, frame_sync, data_enable_out};
  end
endmodule

// [tb/raster_timing_sva.sv]
/* bus and raster checks on the raster_timing ports;
   assumes one aclk domain and tft traffic whenever the shift clock runs */
module raster_timing_sva (
  input wire logic aclk, aresetn, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
  input wire logic s_axi_arready, panel_shift_clock, line_sync, frame_sync, data_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sq;
  int   c, hi, lw, dw;
  wire  tick = panel_shift_clock & !sq;
  // c: aclk cycles since the last shift edge, hi: last high span, lw/dw: pixels
  always_ff @(posedge aclk) begin
    sq <= panel_shift_clock;
    if (!aresetn) {c, hi, lw, dw} <= '0;
    else begin
      c  <= (panel_shift_clock != sq) ? 1 : c + 1;
      if (sq & !panel_shift_clock) hi <= c;
      lw <= line_sync ? 0 : lw + int'(tick);
      dw <= data_enable_out ? dw + int'(tick) : 0;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence b_done; s_axi_bvalid && s_axi_bready; endsequence
  sequence r_done; s_axi_rvalid && s_axi_rready; endsequence
  a_b_once: assert property (b_done |=> !s_axi_bvalid) else $error("bvalid held");
  a_r_once: assert property (r_done |=> !s_axi_rvalid) else $error("rvalid held");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  a_shift_half: assert property (tick && hi != 0 |-> c == hi) else $error("duty");
  a_line_width: assert property ($rose(line_sync) && tick |->
    (lw & 7) == 0 && lw inside {[8:128]}) else $error("line pulse");
  a_de_width: assert property ($fell(data_enable_out) |->
    (dw & 7) == 0 && dw inside {[8:1024]}) else $error("de span");
  a_de_tick: assert property ($changed(data_enable_out) |-> tick) else $error("de");
  a_fs_lead: assert property ($fell(frame_sync) |-> line_sync && tick) else $error("fs");
endmodule
bind raster_timing raster_timing_sva u_sva (.*);

// [tb/raster_timing_tb.sv]
/* register table walk, tft raster figures and a mid-run reset;
   assumes the checker is bound and the panel model watches the tft pins */
module raster_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, panel_shift_clock, line_sync, frame_sync, data_enable_out;
  logic crt_vertical_sync, tv_sync_n, tv_hblank, tv_vblank, tv_burst;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
  int          fails = 0, num_checks = 0, n, k;
  // rows: index, written byte, expected read byte, expected response
  logic [31:0] rows [16] = '{32'h32010100, 32'h34020200, 32'h35010100, 32'h36000000,
    32'h38020200, 32'h39000000, 32'h3a000000, 32'h3c000000, 32'h5a070700, 32'h00550002,
    32'h505a5a00, 32'h52161600, 32'h56e5e500, 32'h57010100, 32'h58121200,
    32'h60010100};
  raster_timing dut (.*);
  panel_model pm (.*);
  always #4 aclk = ~aclk;
  task automatic stop_test;
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin fails++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
    if (nm == "timeout") stop_test;
  endtask
  task automatic wr(input logic [7:0] i, v, output logic [1:0] r);
    {s_axi_awaddr, s_axi_wdata} <= {2'h0, i, 2'h0, 24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    if (n == 50) chk("timeout", 0, 1);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= {2'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
    if (n == 50) chk("timeout", 0, 1);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[k]) begin
      wr(rows[k][31:24], rows[k][23:16], br);
      chk("bresp", rows[k][1:0], br);
      rd(rows[k][31:24], d, rr);
      chk("rdata", rows[k][15:8], d);
      chk("rresp", rows[k][1:0], rr);
    end
    for (n = 0; n < 3000 && pm.frames < 3; n++) @(posedge aclk);
    if (n == 3000) chk("timeout", 0, 1);
    chk("de_len", (1 + 1) * 8, pm.de_len);
    chk("line_len", (1 + 1) * 8 + (2 + 1) * 8, pm.line_len);
    chk("line_low", (0 + 1) * 8, pm.low_len);
    chk("frame_lines", (2 + 1) + (0 + 1), pm.frame_lines);
    chk("fs_lead", 1 * 8 + 1, pm.lead);
    chk("de_rise", (2 + 1) * 8 - 1 * 8 - 6, pm.de_rise);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    #1 chk("idle", 9'h1b0, {line_sync, frame_sync, data_enable_out, crt_vertical_sync,
                            tv_sync_n, tv_hblank, tv_vblank, tv_burst, panel_shift_clock});
    @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h32, d, rr);
    chk("reset_val", 0, d);
    // crt: 16 pixel line pulse offset, line pulse 8 pixels
    wr(8'h50, 8'h01, br);
    wr(8'h53, 8'h01, br);
    wr(8'h60, 8'h03, br);
    for (n = 0; n < 400 && crt_vertical_sync; n++) begin
      @(posedge aclk);
      k = line_sync ? k + 1 : 0;
    end
    if (n == 400) chk("timeout", 0, 1);
    chk("crt_offset", ((1 + 1) * 8 - (0 + 1) * 8) * 2 + 1, k);
    stop_test;
  end
endmodule
